// ### hw/irs_consts.vh
// Function
// R1 - write begins with start, 7-bit address, write bit; device acknowledges address
// R2 - master sends 8-bit register pointer after address; device acknowledges it
// R3 - written byte is committed to pointed register on next rising SDA edge
// R4 - multi-byte write: each byte acknowledged and stored at next register
// R5 - final acknowledge slot of write accepts ack or not-ack without error
// R6 - stop returns input filters to slow setting; repeated start leaves them
// R7 - read: pointer loaded by write, repeated start, address with read bit acked
// R8 - device shifts eight bits MSB first from register the pointer selects
// R9 - master not-acknowledges a single read byte then stops or restarts
// R10 - master ack fetches next register; not-ack ends the read data phase
// R11 - stop leaves register pointer unchanged
// R12 - master code 0000_1xxx after start is not acknowledged by device
// R13 - high-speed mode holds across repeated starts, ends at next stop
// R14 - device answers 0x48 when option is 1, 0x40 when option is 0
// R15 - every pointer value is acknowledged, even for absent registers
// R16 - general call not acknowledged; clock never stretched
// R17 - after stop or address mismatch, SCL ignored until next start
// R18 - pointer increments by one after each transferred data byte; code does not step it after a not-acknowledged read byte
`ifndef IRS_CONSTS_VH
`define IRS_CONSTS_VH
`define IRS_ADDR_OPT1    7'h48
`define IRS_ADDR_OPT0    7'h40
`define IRS_HS_CODE_HI   5'h01
`define IRS_PTR_RESET    8'h00
`define IRS_BIT_LAST     3'h7
`define IRS_BIT_FIRST    3'h0
`endif

// ### hw/irs_i2c_slave.v
`timescale 1ns/1ns
`include "irs_consts.vh"
module irs_i2c_slave
(
  input  wire       clock,
  input  wire       rst_b,
  input  wire       sclIn,
  input  wire       sdaIn,
  output reg        sdaOut,
  output reg        sdaOe,
  output reg        sclOut,
  output reg        sclOe,
  input  wire       addrOption,
  input  wire [7:0] regRdData,
  output reg  [7:0] regAddr,
  output reg  [7:0] regWrData,
  output reg        regWrEn,
  output reg        hsMode,
  output reg        busActive
);
  ////////////////////////////////////////////////////////////////////////
  localparam [5:0] ST_IDLE = 6'b000001;
  localparam [5:0] ST_ADDR = 6'b000010;
  localparam [5:0] ST_PTR  = 6'b000100;
  localparam [5:0] ST_WDAT = 6'b001000;
  localparam [5:0] ST_RDAT = 6'b010000;
  localparam [5:0] ST_RACK = 6'b100000;

  wire sclS;
  wire sdaS;
  reg  sclD_reg;
  reg  sdaD_reg;
  reg  [5:0] state_reg;
  reg  [2:0] bitCnt_reg;
  reg  [7:0] shift_reg;
  reg        ackSlot_reg;
  reg        ackDrive_reg;
  reg        isRead_reg;
  reg  [7:0] pendData_reg;
  reg        pendWr_reg;

  irs_sync uSyncScl (.clock(clock), .rst_b(rst_b), .din(sclIn), .dout(sclS));
  irs_sync uSyncSda (.clock(clock), .rst_b(rst_b), .din(sdaIn), .dout(sdaS));

  // edge and condition detection on synchronised lines
  wire sclRise   = sclS & ~sclD_reg;
  wire sclFall   = ~sclS & sclD_reg;
  wire sdaRise   = sdaS & ~sdaD_reg;
  wire startCond = sclS & sclD_reg & sdaD_reg & ~sdaS;
  wire stopCond  = sclS & sclD_reg & ~sdaD_reg & sdaS;
  wire [7:0] rxByte = {shift_reg[6:0], sdaS};
  wire [6:0] myAddr = addrOption ? `IRS_ADDR_OPT1 : `IRS_ADDR_OPT0; // [R14]
  wire lastBit = (bitCnt_reg == `IRS_BIT_LAST);

  function [7:0] ptrInc;
    input [7:0] p;
    begin
      ptrInc = p + 8'h01;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // protocol engine
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclD_reg     <= 1'b1;
      sdaD_reg     <= 1'b1;
      state_reg    <= ST_IDLE;
      bitCnt_reg   <= `IRS_BIT_FIRST;
      shift_reg    <= 8'h00;
      ackSlot_reg  <= 1'b0;
      ackDrive_reg <= 1'b0;
      isRead_reg   <= 1'b0;
      pendData_reg <= 8'h00;
      pendWr_reg   <= 1'b0;
      regAddr      <= `IRS_PTR_RESET;
      regWrData    <= 8'h00;
      regWrEn      <= 1'b0;
      hsMode       <= 1'b0;
      busActive    <= 1'b0;
      sdaOut       <= 1'b0;
      sdaOe        <= 1'b0;
      sclOut       <= 1'b0;
      sclOe        <= 1'b0;   // clock is never held low [R16]
    end
    else
    begin
      sclD_reg <= sclS;
      sdaD_reg <= sdaS;
      regWrEn  <= 1'b0;
      // pointer steps one cycle after the strobe, so the strobe carries the target [R4] [R18]
      if (regWrEn)
        regAddr <= ptrInc(regAddr);
      // pending byte lands on next rising SDA, any slot result accepted [R3] [R5];
      // the end of the next ack slot also flushes it, so a missed short rise loses no byte
      if (pendWr_reg && (sdaRise || startCond || stopCond ||
          (sclFall && ackSlot_reg && sdaOe && state_reg == ST_WDAT)))
      begin
        regWrEn    <= 1'b1;
        regWrData  <= pendData_reg;
        pendWr_reg <= 1'b0;
      end
      if (stopCond)
      begin
        // pointer kept, filters back to slow, SCL ignored [R6] [R11] [R13] [R17]
        hsMode    <= 1'b0;
        state_reg <= ST_IDLE;
        busActive <= 1'b0;
        sdaOe     <= 1'b0;
      end
      else if (startCond)
      begin
        // repeated start keeps hsMode [R6] [R13]
        state_reg   <= ST_ADDR;
        busActive   <= 1'b1;
        bitCnt_reg  <= `IRS_BIT_FIRST;
        ackSlot_reg <= 1'b0;
        sdaOe       <= 1'b0;
      end
      else if (state_reg != ST_IDLE)
      begin
        if (sclRise && !ackSlot_reg && state_reg != ST_RDAT && state_reg != ST_RACK)
        begin
          shift_reg  <= rxByte;
          bitCnt_reg <= bitCnt_reg + 3'h1;
          if (lastBit)
          begin
            ackSlot_reg  <= 1'b1;
            ackDrive_reg <= 1'b0;
            case (state_reg)
              ST_ADDR:
              begin
                // own address only; general call and master code refused [R1] [R7] [R12] [R16]
                if (rxByte[7:1] == myAddr)
                begin
                  ackDrive_reg <= 1'b1;
                  isRead_reg   <= rxByte[0];
                end
                else if (rxByte[7:3] == `IRS_HS_CODE_HI)
                  hsMode <= 1'b1;      // [R12] [R13]
              end
              ST_PTR:  ackDrive_reg <= 1'b1;  // all pointers acked [R2] [R15]
              ST_WDAT: ackDrive_reg <= 1'b1;  // [R4]
              default: ackDrive_reg <= 1'b0;
            endcase
          end
        end
        else if (sclRise && state_reg == ST_RDAT)
        begin
          bitCnt_reg <= bitCnt_reg + 3'h1;
          if (lastBit)
            state_reg <= ST_RACK;
        end
        else if (sclRise && state_reg == ST_RACK)
        begin
          // master ack asks for next byte, nack ends data phase [R9] [R10]
          if (!sdaS)
          begin
            regAddr    <= ptrInc(regAddr); // [R18]
            state_reg  <= ST_RDAT;
            bitCnt_reg <= `IRS_BIT_FIRST;
          end
          else
            state_reg <= ST_IDLE;
        end
        else if (sclFall)
        begin
          if (ackSlot_reg && !sdaOe)
          begin
            // start of ninth clock low phase: drive ack
            sdaOe  <= ackDrive_reg;
            sdaOut <= 1'b0;
            if (!ackDrive_reg)
            begin
              ackSlot_reg <= 1'b0;
              state_reg   <= ST_IDLE; // mismatch: ignore SCL [R17]
            end
          end
          else if (ackSlot_reg)
          begin
            // ack slot over: choose next phase
            ackSlot_reg <= 1'b0;
            sdaOe       <= 1'b0;
            bitCnt_reg  <= `IRS_BIT_FIRST;
            case (state_reg)
              ST_ADDR:
                if (isRead_reg)
                begin
                  state_reg <= ST_RDAT;
                  sdaOut    <= 1'b0;
                  sdaOe     <= ~regRdData[`IRS_BIT_LAST]; // msb first [R8]
                end
                else
                  state_reg <= ST_PTR;
              ST_PTR:
              begin
                regAddr   <= shift_reg;
                state_reg <= ST_WDAT;
              end
              ST_WDAT:
              begin
                pendData_reg <= shift_reg;   // held for rising SDA [R3]
                pendWr_reg   <= 1'b1;
              end
              default: state_reg <= ST_IDLE;
            endcase
          end
          else if (state_reg == ST_RDAT)
          begin
            // next data bit, open drain: enable drives a zero [R8]
            sdaOut <= 1'b0;
            sdaOe  <= ~regRdData[`IRS_BIT_LAST - bitCnt_reg];
          end
          else if (state_reg == ST_RACK)
            sdaOe <= 1'b0;               // release for master ack
        end
      end
    end
  end
endmodule

// ### hw/irs_sync.v
`timescale 1ns/1ns
// two-flop synchroniser, first stage read only by second
module irs_sync
(
  input  wire clock,
  input  wire rst_b,
  input  wire din,
  output reg  dout
);
  reg meta_reg;
  // resets high to match idle bus level
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= 1'b1;
      dout     <= 1'b1;
    end
    else
    begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule

// ### tb/irs_i2c_slave_monitor.sv
`timescale 1ns/1ns
module irs_i2c_slave_monitor
(
  input wire       clock,
  input wire       rst_b,
  input wire       sclIn,
  input wire       sdaOut,
  input wire       sdaOe,
  input wire       sclOe,
  input wire       sclOut,
  input wire [7:0] regAddr,
  input wire       regWrEn,
  input wire       hsMode,
  input wire       busActive
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_noStretch; !sclOe && !sclOut && !sdaOut; endproperty
  a_noStretch: assert property (p_noStretch) else $error("scl or sda driven high");
  property p_wrPulse; regWrEn |=> !regWrEn; endproperty
  a_wrPulse: assert property (p_wrPulse) else $error("write strobe too long");
  property p_ptrInc; regWrEn |=> regAddr == $past(regAddr) + 8'h01; endproperty
  a_ptrInc: assert property (p_ptrInc) else $error("pointer not advanced");
  // sda may only move while scl is low, or a start or stop is faked
  property p_oeOnLow; $changed(sdaOe) |-> !sclIn; endproperty
  a_oeOnLow: assert property (p_oeOnLow) else $error("sda moved with scl high");
  property p_ackHold; $rose(sdaOe) |-> sdaOe [*8]; endproperty
  a_ackHold: assert property (p_ackHold) else $error("low bit released early");
  property p_hsEnd; $fell(busActive) |=> !hsMode; endproperty
  a_hsEnd: assert property (p_hsEnd) else $error("fast mode kept past stop");
  property p_hsIn; $rose(hsMode) |-> busActive; endproperty
  a_hsIn: assert property (p_hsIn) else $error("fast mode outside frame");
  property p_ptrStop; $fell(busActive) && !regWrEn && !$past(regWrEn) |=> $stable(regAddr); endproperty
  a_ptrStop: assert property (p_ptrStop) else $error("pointer moved at stop");
  property p_idle; !busActive && !$past(busActive) |-> !sdaOe; endproperty
  a_idle: assert property (p_idle) else $error("sda driven while idle");
  c_write: cover property (regWrEn);
  c_fast: cover property ($rose(hsMode));
  c_drive: cover property ($rose(sdaOe));
endmodule

// ### tb/irs_i2c_slave_tb.sv
`timescale 1ns/1ns
module irs_i2c_slave_tb;
  reg        clock, rst_b, addrOption, ack;
  wire       scl, sdaLow, sdaOut, sdaOe, sclOut, sclOe, regWrEn, hsMode, busActive;
  wire [7:0] regAddr, regWrData, regRdData;
  wire       sda = !(sdaOe || sdaLow);
  reg  [7:0] regs [0:255];
  reg  [7:0] mirror [0:255];
  reg  [7:0] ptr, a, d;
  integer    n_fail, checked, i, o;
  always #5 clock = !clock;
  // register space outside the block
  assign regRdData = regs[regAddr];
  always @(posedge clock) if (regWrEn) regs[regAddr] <= regWrData;
  irs_i2c_slave irs_i2c_slave_i (.clock(clock), .rst_b(rst_b), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .sclOut(sclOut), .sclOe(sclOe), .addrOption(addrOption), .regRdData(regRdData),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .hsMode(hsMode), .busActive(busActive));
  irs_master_model irs_master_model_i (.scl(scl), .sdaLow(sdaLow), .sda(sda));
  ////////////////////////////////////////////////////////////////
  function [6:0] own(input op);
    own = op ? 7'h48 : 7'h40;
  endfunction
  task chk(input [63:0] name, input [7:0] exp, input [7:0] got);
  begin
    checked = checked + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("wrong value %0s expected %h seen %h", name, exp, got);
    end
  end
  endtask
  task addr(input rw);
  begin
    irs_master_model_i.start;
    irs_master_model_i.wr({own(addrOption), rw}, ack);
    chk("addrack", 8'h01, {7'h00, ack});
  end
  endtask
  task results;
  begin
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0; rst_b = 1'b0; addrOption = 1'b1; n_fail = 0; checked = 0;
    i = $urandom(11612);
    for (i = 0; i < 256; i = i + 1)
    begin
      regs[i] = 8'h00;
      mirror[i] = 8'h00;
    end
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    chk("ptr", 8'h00, regAddr); // reset value
    for (o = 0; o < 2; o = o + 1)
    begin
      @(posedge clock) addrOption <= o[0];
      // foreign address, then general call: both ignored
      irs_master_model_i.start;
      a = 8'($urandom_range(1, 127));
      irs_master_model_i.wr({own(addrOption) ^ a[6:0], 1'b0}, ack);
      chk("foreign", 8'h00, {7'h00, ack});
      irs_master_model_i.start;
      irs_master_model_i.wr(8'h00, ack);
      chk("gencall", 8'h00, {7'h00, ack});
      irs_master_model_i.stop;
      // burst write; first pass crosses the top of the pointer space
      ptr = o ? 8'($urandom) : 8'hFE;
      addr(1'b0);
      irs_master_model_i.wr(ptr, ack);
      chk("ptrack", 8'h01, {7'h00, ack});
      a = ptr;
      for (i = 0; i < 3; i = i + 1)
      begin
        d = 8'($urandom);
        mirror[a] = d;
        a = a + 8'h01;
        irs_master_model_i.wr(d, ack);
        chk("dataack", 8'h01, {7'h00, ack});
      end
      irs_master_model_i.stop;
      repeat (6) @(posedge clock);
      chk("ptrstop", a, regAddr);
      // reload pointer, restart and read back in sequence
      addr(1'b0);
      irs_master_model_i.wr(ptr, ack);
      addr(1'b1);
      a = ptr;
      for (i = 0; i < 3; i = i + 1)
      begin
        irs_master_model_i.rd(i < 2, d);
        chk("rddata", mirror[a], d);
        a = a + 8'h01;
      end
      irs_master_model_i.stop;
      // master code with random low bits, kept across restart, dropped at stop
      irs_master_model_i.start;
      irs_master_model_i.wr({5'h01, 3'($urandom)}, ack);
      chk("mcode", 8'h00, {7'h00, ack});
      addr(1'b0);
      chk("hs", 8'h01, {7'h00, hsMode});
      irs_master_model_i.stop;
      repeat (4) @(posedge clock);
      chk("hsoff", 8'h00, {7'h00, hsMode});
      $display("option pass %0d done", o);
    end
    results;
  end
endmodule
bind irs_i2c_slave irs_i2c_slave_monitor irs_i2c_slave_monitor_i (.clock(clock), .rst_b(rst_b),
  .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .sclOe(sclOe), .sclOut(sclOut), .regAddr(regAddr),
  .regWrEn(regWrEn), .hsMode(hsMode), .busActive(busActive));

// ### tb/irs_master_model.sv
`timescale 1ns/1ns
// bus master stand-in; sda has a pull-up, so a released line reads high
module irs_master_model
(
  output reg  scl,
  output reg  sdaLow,
  input  wire sda
);
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // one bit per 160 ns, data changed only while scl is low
  task bitx(input b, output s);
  begin
    #40 sdaLow = !b;
    #40 scl = 1'b1;
    #40 s = sda;
    #40 scl = 1'b0;
  end
  endtask
  // start and repeated start alike; clock stands still outside frames
  task start;
  begin
    #1; // keep pin changes off the sampling edge of the block's clock
    #40 sdaLow = 1'b0;
    #40 scl = 1'b1;
    #40 sdaLow = 1'b1;
    #40 scl = 1'b0;
  end
  endtask
  task stop;
  begin
    #40 sdaLow = 1'b1;
    #40 scl = 1'b1;
    #40 sdaLow = 1'b0;
  end
  endtask
  task wr(input [7:0] d, output ack);
    integer i;
    reg     s;
  begin
    for (i = 7; i >= 0; i = i - 1) bitx(d[i], s);
    bitx(1'b1, s);
    ack = !s;
  end
  endtask
  // answer each byte: ack for more, nack on the last one
  task rd(input ackIt, output [7:0] d);
    integer i;
    reg     s;
  begin
    for (i = 7; i >= 0; i = i - 1) bitx(1'b1, d[i]);
    bitx(!ackIt, s);
  end
  endtask
endmodule
